/* File: acquisition_host_bus_port.sv */
// Host-facing parallel bus port of the acquisition system
`timescale 1ns/1ns
`include "host_port_defs.svh"

module acquisition_host_bus_port (
	// Clock and reset
	input  wire logic                     ref_clk,
	input  wire logic                     rst,
	// Host bus control pins
	input  wire logic                     cs_n,
	input  wire logic                     rd_n,
	input  wire logic                     wr_n,
	input  wire logic                     ale,
	input  wire logic [`ADDR_W-1:0]       host_address_lines,
	input  wire logic                     bus_width_select,
	// Host data pins, oe bit 0 for low byte, bit 1 for high byte
	input  wire logic [`DATA_W-1:0]       host_data_lines_in,
	output logic      [`DATA_W-1:0]       host_data_lines_out,
	output logic      [1:0]               host_data_lines_oe,
	// Sync pin
	input  wire logic                     sync_in,
	output logic                          sync_out,
	output logic                          sync_oe,
	// Host signalling outputs
	output logic                          int_n,
	output logic                          fifo_dma_request,
	// Core configuration and sequencing
	input  wire logic                     sync_dir,
	input  wire logic                     conv_begin,
	input  wire logic                     conv_done,
	output logic                          sample_hold,
	output logic                          conv_start,
	output logic                          core_clock_run,
	// Core register access
	output logic      [`WORD_ADDR_W-1:0]  reg_word_addr,
	output logic                          reg_byte_sel,
	output logic                          reg_byte_mode,
	output logic                          reg_rd,
	output logic                          reg_wr,
	output logic      [`DATA_W-1:0]       reg_wdata,
	output logic      [1:0]               reg_byte_en,
	input  wire logic [`DATA_W-1:0]       reg_rdata,
	// Interrupt and FIFO status
	input  wire logic [`IRQ_COUNT-1:0]    irq_events,
	input  wire logic [`IRQ_COUNT-1:0]    irq_enable,
	output logic      [`IRQ_COUNT-1:0]    irq_status,
	input  wire logic [`FIFO_COUNT_W-1:0] fifo_count,
	input  wire logic [`FIFO_COUNT_W-1:0] dma_threshold
);
	// ==========================================
	// Pin synchronisers
	logic                 cs_n_s;
	logic                 rd_n_s;
	logic                 wr_n_s;
	logic                 ale_s;
	logic                 bw_s;
	logic                 sync_s;
	logic [`ADDR_W-1:0]   addr_s;
	logic [`DATA_W-1:0]   data_s;

	pin_sync #(.WIDTH(4), .RESET_VALUE(4'hF)) ctrl_sync (
		.ref_clk (ref_clk),
		.rst     (rst),
		.d       ({cs_n, rd_n, wr_n, ale}),
		.q       ({cs_n_s, rd_n_s, wr_n_s, ale_s})
	);

	pin_sync #(.WIDTH(2), .RESET_VALUE(2'h2)) mode_sync (
		.ref_clk (ref_clk),
		.rst     (rst),
		.d       ({bus_width_select, sync_in}),
		.q       ({bw_s, sync_s})
	);

	pin_sync #(.WIDTH(`ADDR_W), .RESET_VALUE(`ADDR_RESET)) addr_sync (
		.ref_clk (ref_clk),
		.rst     (rst),
		.d       (host_address_lines),
		.q       (addr_s)
	);

	pin_sync #(.WIDTH(`DATA_W), .RESET_VALUE(`DATA_RESET)) data_sync (
		.ref_clk (ref_clk),
		.rst     (rst),
		.d       (host_data_lines_in),
		.q       (data_s)
	);

	// ==========================================
	// Address and chip select latch
	logic [`ADDR_W-1:0] lat_addr;
	logic               lat_cs_n;

	// Transparent while strobe high, frozen from its fall onward
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			lat_addr <= `ADDR_RESET;
			lat_cs_n <= 1'b1;
		end else if (ale_s) begin
			lat_addr <= addr_s;
			lat_cs_n <= cs_n_s;
		end
	end  // Strobe low holds both values

	// ==========================================
	// Access qualification
	logic rd_qual;
	logic wr_qual;
	logic byte_mode;

	assign byte_mode = bw_s;
	assign rd_qual   = !lat_cs_n && !rd_n_s;
	assign wr_qual   = !lat_cs_n && !wr_n_s;

	host_port_pkg::access_state_e state;
	host_port_pkg::access_state_e next_state;

	always_comb begin
		next_state = state;
		case (state)
			host_port_pkg::access_idle: begin
				if (rd_qual) begin
					next_state = host_port_pkg::access_read;
				end else if (wr_qual) begin
					next_state = host_port_pkg::access_write;
				end
			end
			host_port_pkg::access_read: begin
				if (!rd_qual) begin
					next_state = host_port_pkg::access_idle;
				end
			end
			host_port_pkg::access_write: begin
				if (!wr_qual) begin
					next_state = host_port_pkg::access_idle;
				end
			end
			default: begin
				next_state = host_port_pkg::access_idle;
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state <= host_port_pkg::access_idle;
		end else begin
			state <= next_state;
		end
	end

	// ==========================================
	// Address decode toward the core
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			reg_word_addr <= '0;
			reg_byte_sel  <= 1'b0;
			reg_byte_mode <= 1'b0;
		end else begin
			reg_word_addr <= lat_addr[`ADDR_W-1:1];
			reg_byte_sel  <= byte_mode && lat_addr[0];
			reg_byte_mode <= byte_mode;
		end
	end

	// ==========================================
	// Read path
	logic               isr_hit;
	logic [`DATA_W-1:0] word_rd;
	logic [`DATA_W-1:0] lane_rd;

	irq_dma_if fl_bus ();

	assign isr_hit = lat_addr[`ADDR_W-1:1] == `IRQ_STATUS_WORD;
	assign word_rd = isr_hit ? {{(`DATA_W-`IRQ_COUNT){1'b0}}, fl_bus.status} : reg_rdata;
	// Narrow bus returns the addressed byte on the low lines
	assign lane_rd = (byte_mode && lat_addr[0]) ? {`BYTE_W'h00, word_rd[`DATA_W-1:`BYTE_W]}
	                                            : word_rd;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			reg_rd <= 1'b0;
		end else begin
			reg_rd <= state == host_port_pkg::access_idle && next_state == host_port_pkg::access_read;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			host_data_lines_out <= `DATA_RESET;
		end else if (rd_qual) begin
			host_data_lines_out <= byte_mode ? {`BYTE_W'h00, lane_rd[`BYTE_W-1:0]} : lane_rd;
		end
	end

	// Drivers only during a qualified read; high byte only on the wide bus
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			host_data_lines_oe <= 2'h0;
		end else begin
			host_data_lines_oe[0] <= rd_qual;
			host_data_lines_oe[1] <= rd_qual && !byte_mode;
		end
	end

	// ==========================================
	// Write path
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			reg_wdata   <= `DATA_RESET;
			reg_byte_en <= 2'h0;
		end else if (wr_qual) begin
			reg_wdata   <= byte_mode ? {data_s[`BYTE_W-1:0], data_s[`BYTE_W-1:0]} : data_s;
			reg_byte_en <= byte_mode ? (lat_addr[0] ? 2'h2 : 2'h1) : 2'h3;
		end
	end

	// Commit once the write strobe ends, after data has settled
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			reg_wr <= 1'b0;
		end else begin
			reg_wr <= state == host_port_pkg::access_write && !wr_qual;
		end
	end

	// ==========================================
	// Conversion halt while selected
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			core_clock_run <= 1'b1;
		end else begin
			core_clock_run <= lat_cs_n;
		end
	end

	// ==========================================
	// Sync pin
	logic sync_prev;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sync_prev <= 1'b0;
		end else begin
			sync_prev <= sync_s;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sample_hold <= 1'b0;
		end else begin
			sample_hold <= !sync_dir && sync_s && !sync_prev;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			conv_start <= 1'b0;
		end else begin
			conv_start <= sample_hold;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sync_oe <= 1'b0;
		end else begin
			sync_oe <= sync_dir;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sync_out <= 1'b0;
		end else if (!sync_dir) begin
			sync_out <= 1'b0;
		end else if (conv_begin) begin
			sync_out <= 1'b1;
		end else if (conv_done) begin
			sync_out <= 1'b0;
		end
	end

	// ==========================================
	// Interrupt and DMA request
	assign fl_bus.events        = irq_events;
	assign fl_bus.enable        = irq_enable;
	assign fl_bus.fifo_count    = fifo_count;
	assign fl_bus.dma_threshold = dma_threshold;
	// Clear after the host has sampled the status
	assign fl_bus.status_clear  = state == host_port_pkg::access_read && !rd_qual && isr_hit;

	event_flags flags_unit (
		.ref_clk (ref_clk),
		.rst     (rst),
		.fl      (fl_bus.flags)
	);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			int_n            <= 1'b1;
			fifo_dma_request <= 1'b0;
			irq_status       <= `IRQ_STATUS_RESET;
		end else begin
			int_n            <= !fl_bus.int_req;
			fifo_dma_request <= fl_bus.dma_req;
			irq_status       <= fl_bus.status;
		end
	end
endmodule : acquisition_host_bus_port

/* File: acquisition_host_bus_port_tb_top.sv */
// Testbench for the acquisition host bus port
`timescale 1ns/1ns
`include "host_port_defs.svh"

module acquisition_host_bus_port_tb_top;
	// ====================
	// Signals
	logic ref_clk = 1'b0, rst = 1'b1, bus_width_select = 1'b0, sync_in = 1'b0, sync_dir = 1'b0;
	logic conv_begin = 1'b0, conv_done = 1'b0, cs_n, rd_n, wr_n, ale, sync_out, sync_oe, int_n;
	logic fifo_dma_request, sample_hold, conv_start, core_clock_run, reg_byte_sel, reg_byte_mode, reg_rd, reg_wr;
	logic [`ADDR_W-1:0] host_address_lines;
	logic [`DATA_W-1:0] host_data_lines_in, host_data_lines_out, reg_wdata, reg_rdata, q, w_data;
	logic [1:0] host_data_lines_oe, reg_byte_en, o, w_en, w_sel;
	logic [`WORD_ADDR_W-1:0] reg_word_addr, w_addr;
	logic [`IRQ_COUNT-1:0] irq_events = 8'h00, irq_enable = 8'h00, irq_status;
	logic [`FIFO_COUNT_W-1:0] fifo_count = 6'h00, dma_threshold = 6'h00;
	logic [15:0] w_cnt = 16'h0000, r_cnt = 16'h0000;
	int err_count = 0, n_tests = 0, cyc = 0;

	function automatic logic [15:0] word_of(input logic [3:0] w);
		return {4'hA, w, 4'h5, ~w};
	endfunction : word_of

	always #5 ref_clk = ~ref_clk;
	assign reg_rdata = word_of(reg_word_addr);

	acquisition_host_bus_port acquisition_host_bus_port_inst (.ref_clk, .rst, .cs_n, .rd_n, .wr_n, .ale,
		.host_address_lines, .bus_width_select, .host_data_lines_in, .host_data_lines_out, .host_data_lines_oe,
		.sync_in, .sync_out, .sync_oe, .int_n, .fifo_dma_request, .sync_dir, .conv_begin, .conv_done,
		.sample_hold, .conv_start, .core_clock_run, .reg_word_addr, .reg_byte_sel, .reg_byte_mode, .reg_rd,
		.reg_wr, .reg_wdata, .reg_byte_en, .reg_rdata, .irq_events, .irq_enable, .irq_status, .fifo_count,
		.dma_threshold);
	host_bus_model host_bus_model_inst (.ref_clk, .cs_n, .rd_n, .wr_n, .ale, .host_address_lines,
		.host_data_lines_in, .host_data_lines_out, .host_data_lines_oe);

	// Write capture and run limit
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (reg_rd) r_cnt <= r_cnt + 16'h0001;
		if (reg_wr) begin
			w_cnt <= w_cnt + 16'h0001;
			w_sel <= {reg_byte_mode, reg_byte_sel};
			w_addr <= reg_word_addr;
			w_data <= reg_wdata;
			w_en <= reg_byte_en;
		end
		if (cyc == 5000) begin
			err_count++;
			final_report();
		end
	end

	// ====================
	// Tasks
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task acc(input logic [2:0] m, input logic [4:0] a, input logic [15:0] d);
		host_bus_model_inst.access(m, a, d, q, o);
	endtask : acc

	task dma_step(input logic [5:0] c, input logic e);
		fifo_count = c;
		repeat (3) @(negedge ref_clk);
		chk({15'h0000, fifo_dma_request}, {15'h0000, e});
	endtask : dma_step

	task final_report;
		if (err_count == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : final_report

	// ====================
	// Sequence of tests
	initial begin
		repeat (10) @(negedge ref_clk);
		rst = 1'b0;
		@(negedge ref_clk);
		chk({10'h000, host_data_lines_oe, sync_oe, int_n, fifo_dma_request, core_clock_run}, 16'h0005);
		for (int w = 0; w < 16; w++) begin
			acc(3'b000, {w[3:0], 1'b0}, 16'h0000);
			if (w != 9) chk(q, word_of(w[3:0]));
		end
		chk({14'h0000, o}, 16'h0003);
		chk({14'h0000, host_data_lines_oe}, 16'h0000);
		acc(3'b100, 5'h06, 16'h0000);
		chk({14'h0000, o}, 16'h0000);
		acc(3'b010, 5'h0C, 16'h0000);
		chk(q, word_of(4'h6));
		bus_width_select = 1'b1;
		for (int b = 0; b < 2; b++) begin
			acc(3'b000, {4'h5, b[0]}, 16'h0000);
			chk({o, 6'h00, q[7:0]}, {2'b01, 6'h00, b ? 8'hA5 : 8'h5A});
		end
		acc(3'b001, 5'h0B, 16'h0056);
		chk({w_en, 10'h000, w_addr}, 16'h8005);
		chk(w_data, 16'h5656);
		chk({14'h0000, w_sel}, 16'h0003);
		bus_width_select = 1'b0;
		acc(3'b001, 5'h0A, 16'h1234);
		chk({w_en, 10'h000, w_addr}, 16'hC005);
		chk(w_data, 16'h1234);
		chk({14'h0000, w_sel}, 16'h0000);
		acc(3'b101, 5'h0A, 16'hBEEF);
		chk(w_cnt, 16'h0002);
		irq_enable = 8'h04;
		irq_events = 8'h04;
		@(negedge ref_clk);
		irq_events = 8'h10;
		@(negedge ref_clk);
		irq_events = 8'h00;
		repeat (2) @(negedge ref_clk);
		chk({int_n, 7'h00, irq_status}, 16'h0014);
		acc(3'b000, 5'h12, 16'h0000);
		chk({int_n, 7'h00, q[7:0]}, 16'h8014);
		chk({8'h00, irq_status}, 16'h0000);
		irq_events = 8'h10;
		@(negedge ref_clk);
		irq_events = 8'h00;
		repeat (2) @(negedge ref_clk);
		chk({int_n, 7'h00, irq_status}, 16'h8010);
		dma_threshold = 6'h03;
		dma_step(6'h03, 1'b1);
		dma_step(6'h01, 1'b1);
		dma_step(6'h00, 1'b0);
		sync_in = 1'b1;
		repeat (3) @(negedge ref_clk);
		chk({15'h0000, sample_hold}, 16'h0001);
		@(negedge ref_clk);
		chk({14'h0000, sample_hold, conv_start}, 16'h0001);
		sync_dir = 1'b1;
		@(negedge ref_clk);
		conv_begin = 1'b1;
		@(negedge ref_clk);
		conv_begin = 1'b0;
		chk({14'h0000, sync_oe, sync_out}, 16'h0003);
		conv_done = 1'b1;
		@(negedge ref_clk);
		conv_done = 1'b0;
		chk({14'h0000, sync_oe, sync_out}, 16'h0002);
		chk(r_cnt, 16'h0014);
		// Mid-run reset returns the sync pin to input
		sync_in = 1'b0;
		rst = 1'b1;
		@(negedge ref_clk);
		chk({12'h000, sync_oe, sync_out, int_n, fifo_dma_request}, 16'h0002);
		sync_dir = 1'b0;
		rst = 1'b0;
		repeat (3) @(negedge ref_clk);
		chk({14'h0000, sync_oe, core_clock_run}, 16'h0001);
		final_report();
	end
endmodule : acquisition_host_bus_port_tb_top

/* File: event_flags.sv */
// Sticky interrupt flags and FIFO DMA request
`timescale 1ns/1ns
`include "host_port_defs.svh"

module event_flags (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rst,
	// Flag carrier
	irq_dma_if.flags  fl
);
	logic [`IRQ_COUNT-1:0] next_status;

	// Set wins over a clear in the same cycle
	always_comb begin
		next_status = fl.status;
		if (fl.status_clear) begin
			next_status = '0;
		end
		next_status = next_status | fl.events;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			fl.status <= `IRQ_STATUS_RESET;
		end else begin
			fl.status <= next_status;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			fl.int_req <= 1'b0;
		end else begin
			fl.int_req <= |(next_status & fl.enable);
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			fl.dma_req <= 1'b0;
		end else if (fl.fifo_count == fl.dma_threshold && fl.fifo_count != '0) begin
			fl.dma_req <= 1'b1;
		end else if (fl.fifo_count == '0) begin
			fl.dma_req <= 1'b0;
		end
	end
endmodule : event_flags

/* File: host_bus_model.sv */
// Host bus controller model driving the port pins
`timescale 1ns/1ns
`include "host_port_defs.svh"

module host_bus_model (
	// Clock
	input wire logic                ref_clk,
	// Host pins
	output logic                    cs_n,
	output logic                    rd_n,
	output logic                    wr_n,
	output logic                    ale,
	output logic [`ADDR_W-1:0]      host_address_lines,
	output logic [`DATA_W-1:0]      host_data_lines_in,
	input wire logic [`DATA_W-1:0]  host_data_lines_out,
	input wire logic [1:0]          host_data_lines_oe
);
	initial begin
		cs_n = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		ale = 1'b1;
		host_address_lines = 5'h00;
		host_data_lines_in = 16'hFFFF;
	end

	// Mode: bit0 write, bit1 multiplexed, bit2 left unselected
	task access(input logic [2:0] m, input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] d,
		output logic [`DATA_W-1:0] q, output logic [1:0] o);
		@(negedge ref_clk);
		host_address_lines = a;
		cs_n = m[2];
		host_data_lines_in = m[0] ? d : ~host_data_lines_in;
		repeat (4) @(negedge ref_clk);
		if (m[1]) begin
			ale = 1'b0;
			host_address_lines = ~a;
		end
		@(negedge ref_clk);
		if (m[0]) wr_n = 1'b0;
		else rd_n = 1'b0;
		repeat (6) @(negedge ref_clk);
		q = host_data_lines_out;
		o = host_data_lines_oe;
		rd_n = 1'b1;
		wr_n = 1'b1;
		@(negedge ref_clk);
		cs_n = 1'b1;
		ale = 1'b1;
		// Released bus shows the inverse, not a stale value
		host_data_lines_in = ~host_data_lines_in;
		repeat (6) @(negedge ref_clk);
	endtask : access
endmodule : host_bus_model

/* File: host_port_checker.sv */
// Port-level checker for the acquisition host bus port
`timescale 1ns/1ns
`include "host_port_defs.svh"

module host_port_checker (
	// Clock and reset
	input wire logic                     ref_clk,
	input wire logic                     rst,
	// Host pins
	input wire logic                     cs_n,
	input wire logic                     rd_n,
	input wire logic                     wr_n,
	input wire logic                     ale,
	input wire logic                     bus_width_select,
	input wire logic [1:0]               host_data_lines_oe,
	// Sync and signalling
	input wire logic                     sync_in,
	input wire logic                     sync_dir,
	input wire logic                     sync_oe,
	input wire logic                     sync_out,
	input wire logic                     conv_begin,
	input wire logic                     sample_hold,
	input wire logic                     conv_start,
	input wire logic                     core_clock_run,
	input wire logic                     int_n,
	input wire logic                     fifo_dma_request,
	// Core side
	input wire logic [`WORD_ADDR_W-1:0]  reg_word_addr,
	input wire logic                     reg_wr,
	input wire logic [`IRQ_COUNT-1:0]    irq_enable,
	input wire logic [`IRQ_COUNT-1:0]    irq_status,
	input wire logic [`FIFO_COUNT_W-1:0] fifo_count,
	input wire logic [`FIFO_COUNT_W-1:0] dma_threshold
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	// ====================
	// Sequences
	sequence s_rd_idle;
		rd_n [*4];
	endsequence
	sequence s_sync_rise;
		$past(sync_in, 3) && !$past(sync_in, 4);
	endsequence

	// ====================
	// Properties
	a_oe_needs_read: assert property ($rose(|host_data_lines_oe) |-> !rd_n && !$past(rd_n, 3))
		else $error("data driven without read strobe");
	a_oe_read_idle: assert property (s_rd_idle |-> host_data_lines_oe == 2'b00)
		else $error("data driven while read idle");
	a_oe_no_select: assert property ((ale && cs_n) [*6] |-> host_data_lines_oe == 2'b00)
		else $error("data driven while not selected");
	a_upper_lanes_off: assert property (host_data_lines_oe[1] |-> !bus_width_select)
		else $error("upper lanes driven in byte mode");
	a_wr_commit: assert property ($rose(reg_wr) |-> wr_n && !$past(wr_n, 4))
		else $error("write commit without write strobe");
	a_clock_halt: assert property ((ale && !cs_n) [*6] |-> !core_clock_run)
		else $error("core clock runs while selected");
	a_clock_resume: assert property ((ale && cs_n) [*6] |-> core_clock_run)
		else $error("core clock stopped while deselected");
	a_addr_frozen: assert property ((!ale) [*6] |-> $stable(reg_word_addr))
		else $error("address moved while latch closed");
	a_int_cause: assert property (!int_n |-> |(irq_status & irq_enable))
		else $error("interrupt without enabled flag");
	a_dma_match: assert property ((fifo_count == dma_threshold && fifo_count != 6'h00) [*3] |-> fifo_dma_request)
		else $error("dma request missing on count match");
	a_dma_empty: assert property ((fifo_count == 6'h00) [*3] |-> !fifo_dma_request)
		else $error("dma request held with empty fifo");
	a_sample_cause: assert property (sample_hold |-> s_sync_rise)
		else $error("sample without sync rise");
	a_start_follows: assert property (sample_hold |=> conv_start)
		else $error("start missing after sample");
	a_sync_drive: assert property ($changed(sync_dir) |=> sync_oe == $past(sync_dir))
		else $error("sync drive does not follow direction");
	a_sync_begin: assert property (sync_oe && conv_begin |=> sync_out)
		else $error("sync output not raised at start");
endmodule : host_port_checker

bind acquisition_host_bus_port host_port_checker host_port_checker_inst (.ref_clk, .rst, .cs_n, .rd_n, .wr_n,
	.ale, .bus_width_select, .host_data_lines_oe, .sync_in, .sync_dir, .sync_oe, .sync_out, .conv_begin,
	.sample_hold, .conv_start, .core_clock_run, .int_n, .fifo_dma_request, .reg_word_addr, .reg_wr,
	.irq_enable, .irq_status, .fifo_count, .dma_threshold);

/* File: host_port_defs.svh */
// Constants of the acquisition host bus port
// Function
// - Bus width pin high uses low eight data lines; low uses all sixteen.
// - Data drivers enabled and read data shown only while read and select low.
// - Write data accepted only while write strobe and chip select are low.
// - Chip select low halts internal clocking; conversion resumes when it returns high.
// - Address latch strobe high passes address; its falling edge captures address and select.
// - While address latch strobe is low, address and select changes are ignored.
// - Five address lines decode every register, the FIFO and instruction memory.
// - Sync direction low makes sync an input; its rising edge triggers sample-and-hold.
// - Conversion or comparison starts on the clock edge after a sync rising edge.
// - Sync direction high drives sync high at start, low at completion.
// - Reset configures the sync pin as an input.
// - Interrupt output goes low whenever an unmasked interrupt condition of eight occurs.
// - Reading the interrupt status register clears pending interrupts and the output.
// - DMA request rises when FIFO result count equals the programmed count.
// - DMA request falls once the conversion FIFO has been emptied.
// - Sixteen-bit bus selects words by upper four lines; eight-bit adds byte select.
`ifndef HOST_PORT_DEFS_SVH
`define HOST_PORT_DEFS_SVH

// ==========================================
// Address map
`define ADDR_W            5
`define WORD_ADDR_W       4
`define IRQ_STATUS_WORD   4'h9

// ==========================================
// Widths and reset values
`define DATA_W            16
`define BYTE_W            8
`define IRQ_COUNT         8
`define FIFO_COUNT_W      6
`define IRQ_STATUS_RESET  8'h00
`define DATA_RESET        16'h0000
`define ADDR_RESET        5'h00

`endif

/* File: host_port_pkg.sv */
// Types of the acquisition host bus port
package host_port_pkg;

	// ==========================================
	// Host access phases
	typedef enum logic [1:0] {
		access_idle,
		access_read,
		access_write
	} access_state_e;

endpackage : host_port_pkg

/* File: irq_dma_if.sv */
// Carrier between the port and its event flag logic
`timescale 1ns/1ns
`include "host_port_defs.svh"

interface irq_dma_if;
	logic [`IRQ_COUNT-1:0]    events;
	logic [`IRQ_COUNT-1:0]    enable;
	logic                     status_clear;
	logic [`FIFO_COUNT_W-1:0] fifo_count;
	logic [`FIFO_COUNT_W-1:0] dma_threshold;
	logic [`IRQ_COUNT-1:0]    status;
	logic                     int_req;
	logic                     dma_req;

	modport port (
		output events, enable, status_clear, fifo_count, dma_threshold,
		input  status, int_req, dma_req
	);
	modport flags (
		input  events, enable, status_clear, fifo_count, dma_threshold,
		output status, int_req, dma_req
	);
endinterface : irq_dma_if

/* File: pin_sync.sv */
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ns

module pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst,
	// Data
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] stage1;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			stage1 <= RESET_VALUE;
			q      <= RESET_VALUE;
		end else begin
			stage1 <= d;
			q      <= stage1;
		end
	end
endmodule : pin_sync
